// ### inc/hop_sequencer_pkg.sv
// Constants, register map and state type for the hop sequencer
package hop_sequencer_pkg;

  // ************************************************************
  // Clock and dwell timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_MIN_NS = 200;
  localparam int DWELL_MAX_S = 20;
  // Least time rounds up to whole cycles
  localparam logic [31:0] DWELL_MIN_CYC =
    32'((DWELL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Longest time rounds down; the product needs 64 bits
  localparam logic [31:0] DWELL_MAX_CYC_DEF =
    32'(64'(DWELL_MAX_S) * 64'd1000000000 / 64'(CLK_PERIOD_NS));

  // ************************************************************
  // Table and marker sizes
  // ************************************************************
  localparam int TBL_DEPTH = 10000;
  localparam int TBL_ADDR_W = 14;
  localparam int STEP_W = 13;
  localparam logic [STEP_W-1:0] STEP_MAX = 13'h1388;
  localparam logic [STEP_W-1:0] MARK_MIN = 13'h0001;
  localparam int LEVEL_W = 16;

  // ************************************************************
  // Register map (word addresses on the plain port)
  // ************************************************************
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FREQ_DWELL = 4'h1;
  localparam logic [3:0] REG_LEVEL_DWELL = 4'h2;
  localparam logic [3:0] REG_FREQ_MARK = 4'h3;
  localparam logic [3:0] REG_LEVEL_MARK = 4'h4;
  localparam logic [3:0] REG_CARRIER_FREQ = 4'h5;
  localparam logic [3:0] REG_LEVEL = 4'h6;
  localparam logic [3:0] REG_TBL_CLEAR = 4'h7;
  localparam logic [3:0] REG_TBL_DATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_TBL_COUNT = 4'hA;

  // Control fields; mode bit 0 reads as FIX, 1 as VAR
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TARGET_BIT = 1;
  localparam int CTRL_FMODE_BIT = 2;
  localparam int CTRL_LMODE_BIT = 3;
  localparam logic MODE_FIX = 1'b0;
  localparam logic MODE_VAR = 1'b1;
  localparam logic TARGET_FREQ = 1'b0;
  localparam logic TARGET_LEVEL = 1'b1;

  // Status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_STEP_LSB = 16;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] CW_RESET = 32'h0100_0000;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 16'h8000;

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_V, S_TAKE_V, S_WAIT_D, S_TAKE_D, S_DWELL, S_FINISH
  } seq_state_type;

endpackage

// ### design/carrier_phase_accum.sv
// Phase accumulator for the sine carrier with end-of-cycle pulse
`timescale 1ns/1ns
module carrier_phase_accum (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] step_i,
  output logic [31:0] phase_o,
  output logic wrap_o
);

  logic [31:0] phase_reg;
  logic [31:0] phase_next;
  logic wrap_reg;
  logic wrap_next;
  logic [32:0] sum;

  // Carry out of the accumulator marks the end of one carrier cycle
  always_comb begin
    sum = {1'b0, phase_reg} + {1'b0, step_i};
    phase_next = sum[31:0];
    wrap_next = sum[32];
  end

  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase_reg <= 32'h0000_0000;
      wrap_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      wrap_reg <= wrap_next;
    end
  end

  assign phase_o = phase_reg;
  assign wrap_o = wrap_reg;

endmodule

// ### design/hop_sequencer.sv
// Table-driven frequency or level hop sequencer for a sine carrier
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
module hop_sequencer
  import hop_sequencer_pkg::*;
#(
  parameter logic [31:0] DWELL_MAX_CYC = DWELL_MAX_CYC_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [31:0] carrier_frequency_o,
  output logic [LEVEL_W-1:0] carrier_level_o,
  output logic [31:0] carrier_phase_o,
  output logic sync_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic run_reg, run_next;
  logic target_reg, target_next;
  logic frequency_step_mode_reg, frequency_step_mode_next;
  logic level_step_mode_reg, level_step_mode_next;
  logic [31:0] freq_dwell_reg, freq_dwell_next;
  logic [31:0] level_dwell_reg, level_dwell_next;
  logic [STEP_W-1:0] freq_mark_reg, freq_mark_next;
  logic [STEP_W-1:0] level_mark_reg, level_mark_next;
  logic [31:0] cw_reg, cw_next;
  logic [LEVEL_W-1:0] level_reg, level_next;
  logic [TBL_ADDR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [STEP_W-1:0] mark_use_reg, mark_use_next;
  logic [31:0] rdata_reg, rdata_next;

  seq_state_type state_reg, state_next;
  logic [TBL_ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic [STEP_W-1:0] step_reg, step_next;
  logic [STEP_W-1:0] steps_reg, steps_next;
  logic var_use_reg, var_use_next;
  logic target_use_reg, target_use_next;
  logic [31:0] dwell_use_reg, dwell_use_next;
  logic [31:0] dwell_cnt_reg, dwell_cnt_next;
  logic [31:0] freq_out_reg, freq_out_next;
  logic [LEVEL_W-1:0] level_out_reg, level_out_next;
  logic sync_reg, sync_next;

  logic [31:0] tbl_mem [TBL_DEPTH];
  logic [31:0] mem_q_reg;
  logic tbl_we;
  logic [TBL_ADDR_W-1:0] seq_words;
  logic [STEP_W-1:0] seq_len;
  logic seq_var;
  logic wrap;
  logic cycle_end;
  logic hopping;

  // Keeps a common dwell inside 200 ns..20 s in clock cycles
  function automatic logic [31:0] clamp_dwell(input logic [31:0] v);
    if (v < DWELL_MIN_CYC) begin
      return DWELL_MIN_CYC;
    end
    if (v > DWELL_MAX_CYC) begin
      return DWELL_MAX_CYC;
    end
    return v;
  endfunction

  // Keeps a marker index inside 1..5000
  function automatic logic [STEP_W-1:0] clamp_mark(input logic [31:0] v);
    if (v < 32'(MARK_MIN)) begin
      return MARK_MIN;
    end
    if (v > 32'(STEP_MAX)) begin
      return STEP_MAX;
    end
    return v[STEP_W-1:0];
  endfunction

  // ************************************************************
  // Register file
  // ************************************************************
  // Table loads are refused while a sequence runs
  assign tbl_we = reg_wr_i && (reg_addr_i == REG_TBL_DATA)
    && (state_reg == S_IDLE) && (32'(wr_ptr_reg) < TBL_DEPTH);

  // Software writes and read-back mux
  always_comb begin
    run_next = run_reg;
    target_next = target_reg;
    frequency_step_mode_next = frequency_step_mode_reg;
    level_step_mode_next = level_step_mode_reg;
    freq_dwell_next = freq_dwell_reg;
    level_dwell_next = level_dwell_reg;
    freq_mark_next = freq_mark_reg;
    level_mark_next = level_mark_reg;
    cw_next = cw_reg;
    level_next = level_reg;
    wr_ptr_next = wr_ptr_reg;
    mark_use_next = mark_use_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          run_next = reg_wdata_i[CTRL_RUN_BIT];
          target_next = reg_wdata_i[CTRL_TARGET_BIT];
          frequency_step_mode_next = reg_wdata_i[CTRL_FMODE_BIT];
          level_step_mode_next = reg_wdata_i[CTRL_LMODE_BIT];
        end
        REG_FREQ_DWELL: freq_dwell_next = clamp_dwell(reg_wdata_i);
        REG_LEVEL_DWELL: level_dwell_next = clamp_dwell(reg_wdata_i);
        REG_FREQ_MARK: freq_mark_next = clamp_mark(reg_wdata_i);
        REG_LEVEL_MARK: level_mark_next = clamp_mark(reg_wdata_i);
        REG_CARRIER_FREQ: cw_next = reg_wdata_i;
        REG_LEVEL: level_next = reg_wdata_i[LEVEL_W-1:0];
        REG_TBL_CLEAR: begin
          // Marker is frozen when a download begins
          if (state_reg == S_IDLE) begin
            wr_ptr_next = '0;
            mark_use_next = target_reg ? level_mark_reg : freq_mark_reg;
          end
        end
        REG_TBL_DATA: begin
          if (tbl_we) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          rdata_next[CTRL_RUN_BIT] = run_reg;
          rdata_next[CTRL_TARGET_BIT] = target_reg;
          rdata_next[CTRL_FMODE_BIT] = frequency_step_mode_reg;
          rdata_next[CTRL_LMODE_BIT] = level_step_mode_reg;
        end
        REG_FREQ_DWELL: rdata_next = freq_dwell_reg;
        REG_LEVEL_DWELL: rdata_next = level_dwell_reg;
        REG_FREQ_MARK: rdata_next = 32'(freq_mark_reg);
        REG_LEVEL_MARK: rdata_next = 32'(level_mark_reg);
        REG_CARRIER_FREQ: rdata_next = cw_reg;
        REG_LEVEL: rdata_next = 32'(level_reg);
        REG_STATUS: begin
          rdata_next[STAT_RUN_BIT] = (state_reg != S_IDLE);
          rdata_next[STAT_STEP_LSB +: STEP_W] = step_reg;
        end
        REG_TBL_COUNT: rdata_next = 32'(wr_ptr_reg);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
      target_reg <= TARGET_FREQ;
      frequency_step_mode_reg <= MODE_FIX;
      level_step_mode_reg <= MODE_FIX;
      freq_dwell_reg <= DWELL_MIN_CYC;
      level_dwell_reg <= DWELL_MIN_CYC;
      freq_mark_reg <= MARK_MIN;
      level_mark_reg <= MARK_MIN;
      cw_reg <= CW_RESET;
      level_reg <= LEVEL_RESET;
      wr_ptr_reg <= '0;
      mark_use_reg <= MARK_MIN;
      rdata_reg <= 32'h0000_0000;
    end else begin
      run_reg <= run_next;
      target_reg <= target_next;
      frequency_step_mode_reg <= frequency_step_mode_next;
      level_step_mode_reg <= level_step_mode_next;
      freq_dwell_reg <= freq_dwell_next;
      level_dwell_reg <= level_dwell_next;
      freq_mark_reg <= freq_mark_next;
      level_mark_reg <= level_mark_next;
      cw_reg <= cw_next;
      level_reg <= level_next;
      wr_ptr_reg <= wr_ptr_next;
      mark_use_reg <= mark_use_next;
      rdata_reg <= rdata_next;
    end
  end

  // Table storage, one-cycle registered read
  always_ff @(posedge sys_clk_i) begin
    if (tbl_we) begin
      tbl_mem[wr_ptr_reg] <= reg_wdata_i;
    end
    mem_q_reg <= tbl_mem[rd_addr_reg];
  end

  // ************************************************************
  // Carrier and hop sequencer
  // ************************************************************
  carrier_phase_accum u_phase (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .step_i(freq_out_reg),
    .phase_o(carrier_phase_o),
    .wrap_o(wrap)
  );

  // Zero frequency never wraps, so it must not stall the sequence
  assign cycle_end = wrap || (freq_out_reg == 32'h0000_0000);
  assign hopping = (state_reg != S_IDLE);

  // Pairs halve the step count; odd trailing word is ignored
  assign seq_var = target_reg ? level_step_mode_reg : frequency_step_mode_reg;
  assign seq_words = seq_var ? (wr_ptr_reg >> 1) : wr_ptr_reg;
  assign seq_len = (seq_words > TBL_ADDR_W'(STEP_MAX)) ? STEP_MAX
    : seq_words[STEP_W-1:0];

  // Next-state logic of the sequencer
  always_comb begin
    state_next = state_reg;
    rd_addr_next = rd_addr_reg;
    step_next = step_reg;
    steps_next = steps_reg;
    var_use_next = var_use_reg;
    target_use_next = target_use_reg;
    dwell_use_next = dwell_use_reg;
    dwell_cnt_next = dwell_cnt_reg;
    freq_out_next = freq_out_reg;
    level_out_next = level_out_reg;
    sync_next = 1'b0;
    // Static settings drive whatever is not being hopped
    if (!hopping || target_use_reg == TARGET_LEVEL) begin
      freq_out_next = cw_reg;
    end
    if (!hopping || target_use_reg == TARGET_FREQ) begin
      level_out_next = level_reg;
    end
    unique case (state_reg)
      S_IDLE: begin
        if (run_reg && seq_len != '0) begin
          // Mode and common dwell frozen for the whole sequence
          var_use_next = seq_var;
          target_use_next = target_reg;
          dwell_use_next = target_reg ? level_dwell_reg : freq_dwell_reg;
          steps_next = seq_len;
          step_next = '0;
          rd_addr_next = '0;
          state_next = S_WAIT_V;
        end
      end
      S_WAIT_V: state_next = S_TAKE_V;
      S_TAKE_V: begin
        if (target_use_reg == TARGET_LEVEL) begin
          level_out_next = mem_q_reg[LEVEL_W-1:0];
        end else begin
          freq_out_next = mem_q_reg;
        end
        sync_next = ((step_reg + 1'b1) == mark_use_reg);
        if (var_use_reg) begin
          rd_addr_next = rd_addr_reg + 1'b1;
          state_next = S_WAIT_D;
        end else begin
          dwell_cnt_next = dwell_use_reg;
          state_next = S_DWELL;
        end
      end
      S_WAIT_D: state_next = S_TAKE_D;
      S_TAKE_D: begin
        // Common dwell plays no part here
        dwell_cnt_next = (mem_q_reg == 32'h0000_0000) ? 32'h0000_0001 : mem_q_reg;
        state_next = S_DWELL;
      end
      S_DWELL: begin
        if (dwell_cnt_reg <= 32'h0000_0001) begin
          state_next = S_FINISH;
        end else begin
          dwell_cnt_next = dwell_cnt_reg - 1'b1;
        end
      end
      S_FINISH: begin
        if (cycle_end) begin
          if (step_reg == steps_reg - 1'b1) begin
            step_next = '0;
            rd_addr_next = '0;
          end else begin
            step_next = step_reg + 1'b1;
            rd_addr_next = rd_addr_reg + 1'b1;
          end
          state_next = S_WAIT_V;
        end
      end
    endcase
    // A stop clears the step so idle status reads zero, and drops a marker
    // that would otherwise belong to a step that never plays
    if (!run_reg) begin
      state_next = S_IDLE;
      step_next = '0;
      sync_next = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      rd_addr_reg <= '0;
      step_reg <= '0;
      steps_reg <= '0;
      var_use_reg <= MODE_FIX;
      target_use_reg <= TARGET_FREQ;
      dwell_use_reg <= DWELL_MIN_CYC;
      dwell_cnt_reg <= 32'h0000_0000;
      freq_out_reg <= CW_RESET;
      level_out_reg <= LEVEL_RESET;
      sync_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rd_addr_reg <= rd_addr_next;
      step_reg <= step_next;
      steps_reg <= steps_next;
      var_use_reg <= var_use_next;
      target_use_reg <= target_use_next;
      dwell_use_reg <= dwell_use_next;
      dwell_cnt_reg <= dwell_cnt_next;
      freq_out_reg <= freq_out_next;
      level_out_reg <= level_out_next;
      sync_reg <= sync_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign carrier_frequency_o = freq_out_reg;
  assign carrier_level_o = level_out_reg;
  assign sync_o = sync_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_freq_hop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_TAKE_V && target_use_reg == TARGET_FREQ && run_reg)
      |=> carrier_frequency_o == $past(mem_q_reg);
  endproperty
  a_freq_hop: assert property (p_freq_hop) else $error("frequency hop lost");

  property p_level_hop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_TAKE_V && target_use_reg == TARGET_LEVEL && run_reg)
      |=> carrier_level_o == $past(mem_q_reg[LEVEL_W-1:0]);
  endproperty
  a_level_hop: assert property (p_level_hop) else $error("level hop lost");

  property p_cycle_done;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_FINISH && !cycle_end && run_reg) |=> state_reg == S_FINISH;
  endproperty
  a_cycle_done: assert property (p_cycle_done) else $error("hop mid cycle");

  property p_var_dwell;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_TAKE_D && run_reg && mem_q_reg != 32'h0000_0000)
      |=> state_reg == S_DWELL && dwell_cnt_reg == $past(mem_q_reg);
  endproperty
  a_var_dwell: assert property (p_var_dwell) else $error("table dwell wrong");

  property p_fix_dwell;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_TAKE_V && !var_use_reg && run_reg)
      |=> dwell_cnt_reg == dwell_use_reg ##1 dwell_cnt_reg == dwell_use_reg - 1;
  endproperty
  a_fix_dwell: assert property (p_fix_dwell) else $error("fixed dwell wrong");

  property p_dwell_range;
    @(posedge sys_clk_i) disable iff (rst_i)
    freq_dwell_reg >= DWELL_MIN_CYC && level_dwell_reg >= DWELL_MIN_CYC
      && freq_dwell_reg <= DWELL_MAX_CYC && level_dwell_reg <= DWELL_MAX_CYC;
  endproperty
  a_dwell_range: assert property (p_dwell_range) else $error("dwell out of range");

  property p_mark_range;
    @(posedge sys_clk_i) disable iff (rst_i)
    freq_mark_reg >= MARK_MIN && freq_mark_reg <= STEP_MAX
      && level_mark_reg >= MARK_MIN && level_mark_reg <= STEP_MAX;
  endproperty
  a_mark_range: assert property (p_mark_range) else $error("marker out of range");

  property p_sync_pos;
    @(posedge sys_clk_i) disable iff (rst_i)
    sync_o |-> (step_reg + 1'b1) == mark_use_reg && $past(state_reg) == S_TAKE_V;
  endproperty
  a_sync_pos: assert property (p_sync_pos) else $error("marker misplaced");

  property p_sync_width;
    @(posedge sys_clk_i) disable iff (rst_i)
    sync_o |=> !sync_o [*2];
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("marker too long");

  property p_wrap_first;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_FINISH && cycle_end && run_reg && step_reg == steps_reg - 1'b1)
      |=> step_reg == '0 && rd_addr_reg == '0 ##1 state_reg == S_TAKE_V;
  endproperty
  a_wrap_first: assert property (p_wrap_first) else $error("no wrap to first");

  property p_mode_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == REG_CTRL)
      |=> reg_rdata_o[CTRL_LMODE_BIT] == $past(level_step_mode_reg)
        && reg_rdata_o[CTRL_FMODE_BIT] == $past(frequency_step_mode_reg);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

endmodule

// ### testbench/tb.sv
// Self-checking bench for the hop sequencer through its register port
`timescale 1ns/1ns
module tb
  import hop_sequencer_pkg::*;
;
  // ************************************************************
  // Clock, reset and design hookup
  // ************************************************************
  localparam logic [31:0] DMAX = 32'h0000_0064;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [REG_ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, cf, ph;
  logic [LEVEL_W-1:0] lv;
  logic sync;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] cw = CW_RESET;
  logic [31:0] vals[4];
  int lens[4];
  int syns[4];
  bit wrps[4];

  hop_sequencer #(.DWELL_MAX_CYC(DMAX)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .carrier_frequency_o(cf), .carrier_level_o(lv),
    .carrier_phase_o(ph), .sync_o(sync));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Ceiling well above the slowest run so a hang still ends in a verdict
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the read edge, sampled there
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    rd <= 1'b1; addr <= a;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk($sformatf("reg %0d", a), exp, d);
  endtask

  // Records n steps: value, length, sync count (+100 if high on the first cycle), wrap seen
  task automatic watch(input bit lvl, input int n);
    logic [31:0] cur, v, pp;
    int k, len, s;
    bit w;
    cur = lvl ? 32'(lv) : cf;
    pp = ph;
    k = -1; len = 0; s = 0; w = 0;
    while (k < n) begin
      @(posedge sys_clk_i);
      #1 v = lvl ? 32'(lv) : cf;
      if (v !== cur) begin
        if (k >= 0) begin
          lens[k] = len; syns[k] = s; wrps[k] = w;
        end
        k++;
        if (k < n) vals[k] = v;
        cur = v; len = 0; s = 0; w = 0;
        if (sync === 1'b1) s = 100;
      end
      len++;
      if (sync === 1'b1) s++;
      if (ph < pp) w = 1;
      pp = ph;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk_reg(REG_CTRL, 32'h0000_0000);
    chk_reg(REG_FREQ_DWELL, DWELL_MIN_CYC);
    chk_reg(REG_LEVEL_DWELL, DWELL_MIN_CYC);
    chk_reg(REG_FREQ_MARK, 32'(MARK_MIN));
    chk_reg(REG_LEVEL_MARK, 32'(MARK_MIN));
    chk_reg(REG_CARRIER_FREQ, CW_RESET);
    chk_reg(REG_LEVEL, 32'(LEVEL_RESET));
    chk_reg(REG_TBL_COUNT, 32'h0000_0000);
    chk("carrier", CW_RESET, cf);
    chk("level", 32'(LEVEL_RESET), 32'(lv));
    chk("sync idle", 32'h0000_0000, 32'(sync));
  endtask

  // Limits of the settings, read-only and unmapped places, mode readback
  task automatic t_regs();
    wr_reg(REG_FREQ_DWELL, 32'h0000_03E8);
    chk_reg(REG_FREQ_DWELL, DMAX);
    wr_reg(REG_LEVEL_DWELL, 32'h0000_0005);
    chk_reg(REG_LEVEL_DWELL, DWELL_MIN_CYC);
    wr_reg(REG_FREQ_MARK, 32'h0000_0000);
    chk_reg(REG_FREQ_MARK, 32'(MARK_MIN));
    wr_reg(REG_LEVEL_MARK, 32'h0000_1770);
    chk_reg(REG_LEVEL_MARK, 32'(STEP_MAX));
    wr_reg(REG_LEVEL_MARK, 32'h0000_1387);
    chk_reg(REG_LEVEL_MARK, 32'h0000_1387);
    wr_reg(REG_CTRL, 32'h0000_000C);
    chk_reg(REG_CTRL, 32'h0000_000C);
    wr_reg(REG_CTRL, 32'h0000_0000);
    wr_reg(REG_STATUS, 32'hFFFF_FFFF);
    chk_reg(REG_STATUS, 32'h0000_0000);
    wr_reg(REG_TBL_COUNT, 32'h0000_0005);
    chk_reg(REG_TBL_COUNT, 32'h0000_0000);
    chk_reg(4'hF, 32'h0000_0000);
    cw = 32'h2000_0000;
    wr_reg(REG_CARRIER_FREQ, cw);
  endtask

  // Load a three-step table, run four steps, judge each, then stop
  task automatic run_hop(input bit lvl, input bit vm, input int mark, input int cdw,
      input logic [31:0] v0, v1, v2, input int d0, d1, d2);
    logic [31:0] v[3], ctl, st, fr, ev;
    int d[3];
    int j, dw, ovh, per;
    v = '{v0, v1, v2};
    d = '{d0, d1, d2};
    wr_reg(lvl ? REG_LEVEL_MARK : REG_FREQ_MARK, 32'(mark));
    wr_reg(lvl ? REG_LEVEL_DWELL : REG_FREQ_DWELL, 32'(cdw));
    // The clear latches the marker of the current target, so aim it first
    wr_reg(REG_CTRL, 32'(lvl) << CTRL_TARGET_BIT);
    wr_reg(REG_TBL_CLEAR, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr_reg(REG_TBL_DATA, v[i]);
      if (vm) wr_reg(REG_TBL_DATA, 32'(d[i]));
    end
    if (vm) wr_reg(REG_TBL_DATA, 32'h0000_4444);
    chk_reg(REG_TBL_COUNT, vm ? 32'h0000_0007 : 32'h0000_0003);
    ctl = 32'h0000_0001 | (32'(lvl) << CTRL_TARGET_BIT);
    ctl = ctl | (32'(vm) << (lvl ? CTRL_LMODE_BIT : CTRL_FMODE_BIT));
    wr_reg(REG_CTRL, ctl);
    watch(lvl, 4);
    for (int i = 0; i < 4; i++) begin
      j = i % 3;
      dw = vm ? ((d[j] == 0) ? 1 : d[j]) : cdw;
      ovh = vm ? 4 : 2;
      fr = lvl ? cw : v[j];
      per = int'((64'h0000_0001_0000_0000 + 64'(fr) - 64'h1) / 64'(fr));
      ev = lvl ? {16'h0000, v[j][15:0]} : v[j];
      chk("step value", ev, vals[i]);
      chk_rng("step length", dw + ovh, dw + ovh + per + 3, lens[i]);
      chk("sync", (j == mark - 1) ? 32'd101 : 32'd0, 32'(syns[i]));
      chk("carrier wrap", 32'd1, 32'(wrps[i]));
    end
    if (lvl) chk("carrier", cw, cf);
    chk_reg(REG_CTRL, ctl);
    rd_reg(REG_STATUS, st);
    chk("running", 32'd1, 32'(st[STAT_RUN_BIT]));
    wr_reg(REG_TBL_DATA, 32'h0000_5555);
    chk_reg(REG_TBL_COUNT, vm ? 32'h0000_0007 : 32'h0000_0003);
    wr_reg(REG_CTRL, 32'h0000_0000);
    chk_reg(REG_STATUS, 32'h0000_0000);
    chk("stop carrier", cw, cf);
    chk("stop level", 32'(LEVEL_RESET), 32'(lv));
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    run_hop(0, 0, 2, 20, 32'h8000_0000, 32'h0100_0000, 32'h4000_0000, 0, 0, 0);
    run_hop(0, 1, 3, 100, 32'h4000_0000, 32'h8000_0000, 32'h0100_0000, 30, 5, 0);
    run_hop(1, 0, 1, 40, 32'h0000_1111, 32'h0000_2222, 32'h0000_3333, 0, 0, 0);
    run_hop(1, 1, 3, 100, 32'h0000_AAAA, 32'h0000_0123, 32'h0000_FFFF, 7, 0, 25);
    final_report();
  end
endmodule
